// ==== rtl/spcg_pkg.sv ====
// Package: register map, field layout and state codes for sleep port clock gating
package spcg_pkg;
    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [11:0] OFS_RUN_GATE = 12'h108;
    localparam logic [11:0] OFS_SLEEP_GATE = 12'h118;
    localparam logic [11:0] OFS_DEEP_GATE = 12'h128;
    localparam logic [11:0] OFS_CLK_CFG = 12'h060;
    localparam logic [11:0] OFS_IRQ_STATUS = 12'h200;
    localparam logic [11:0] OFS_IRQ_ENABLE = 12'h204;
    localparam logic [11:0] OFS_IRQ_CLEAR = 12'h208;
    localparam logic [11:0] OFS_POWER_STATE = 12'h20C;

    // ****************************************
    // Field layout and reset values
    // ****************************************
    localparam int NUM_PORTS = 8;
    localparam int CFG_AUTO_GATE_BIT = 27;
    localparam logic [7:0] GATE_RESET = 8'h00;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [3:0] IRQ_RESET = 4'h0;
    localparam int IRQ_FAULT_BIT = 0;
    localparam int IRQ_MODE_BIT = 1;
    localparam int IRQ_WIDTH = 4;

    // ****************************************
    // Power modes
    // ****************************************
    typedef enum logic [2:0] {
        SPCG_RUN = 3'b001,
        SPCG_SLEEP = 3'b010,
        SPCG_DEEP = 3'b100
    } spcg_mode_t;

    // Bus slave states
    typedef enum logic [1:0] {
        SPCG_IDLE = 2'b01,
        SPCG_DONE = 2'b10
    } spcg_bus_t;
endpackage

// ==== rtl/spcg_top.sv ====
// Module: sleep-mode port clock gating control with register slave and port fault check
`timescale 1ns/1ns
module spcg_top #(
    parameter int PORTS = 8
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // Avalon-MM register slave
    input wire logic [11:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output logic [1:0] o_avs_response,
    // Power mode requests from the system controller, asynchronous
    input wire logic i_sleep_req,
    input wire logic i_deep_sleep_req,
    // Port module accesses from the processor fabric, same clock
    input wire logic i_port_access,
    input wire logic [2:0] i_port_select,
    output logic o_port_fault,
    // Clock enables to the port modules
    output logic [PORTS-1:0] o_port_clock_en,
    // Interrupt
    output logic o_irq
);
    // ****************************************
    // Mode request synchronisers
    // ****************************************
    // Requests come from another domain; only the second flop feeds the mode logic
    logic [1:0] sleep_sync;
    logic [1:0] deep_sync;
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            sleep_sync <= 2'h0;
        end else begin
            sleep_sync <= {sleep_sync[0], i_sleep_req};
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            deep_sync <= 2'h0;
        end else begin
            deep_sync <= {deep_sync[0], i_deep_sleep_req};
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    logic [PORTS-1:0] run_port_clock_gate;
    logic [PORTS-1:0] sleep_port_clock_gate;
    logic [PORTS-1:0] deep_sleep_port_clock_gate;
    logic [31:0] run_mode_clock_config;
    logic [spcg_pkg::IRQ_WIDTH-1:0] irq_status;
    logic [spcg_pkg::IRQ_WIDTH-1:0] irq_enable;
    spcg_pkg::spcg_mode_t mode;
    spcg_pkg::spcg_mode_t next_mode;
    spcg_pkg::spcg_bus_t bus_state;
    logic [31:0] read_word;
    logic [1:0] resp;
    logic [PORTS-1:0] gate_now;

    // Reserved bits above the port field are never stored, so they read back as zero
    function automatic logic [31:0] zext_ports(input logic [PORTS-1:0] v);
        return {{(32-PORTS){1'b0}}, v};
    endfunction

    // Byte-lane merge; lanes with a clear enable keep their old value
    function automatic logic [31:0] merge_lanes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0] be);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // ****************************************
    // Address decode
    // ****************************************
    // A new access is taken only from idle, so each request is answered once
    wire logic access_start = (i_avs_read | i_avs_write) && (bus_state == spcg_pkg::SPCG_IDLE);
    wire logic wr_start = i_avs_write && (bus_state == spcg_pkg::SPCG_IDLE);
    wire logic hit_run = (i_avs_address == spcg_pkg::OFS_RUN_GATE);
    wire logic hit_sleep = (i_avs_address == spcg_pkg::OFS_SLEEP_GATE);
    wire logic hit_deep = (i_avs_address == spcg_pkg::OFS_DEEP_GATE);
    wire logic hit_cfg = (i_avs_address == spcg_pkg::OFS_CLK_CFG);
    wire logic hit_ists = (i_avs_address == spcg_pkg::OFS_IRQ_STATUS);
    wire logic hit_ien = (i_avs_address == spcg_pkg::OFS_IRQ_ENABLE);
    wire logic hit_iclr = (i_avs_address == spcg_pkg::OFS_IRQ_CLEAR);
    wire logic hit_pwr = (i_avs_address == spcg_pkg::OFS_POWER_STATE);
    wire logic hit_any = hit_run | hit_sleep | hit_deep | hit_cfg | hit_ists | hit_ien
                         | hit_iclr | hit_pwr;
    // Register views as software reads them
    wire logic [31:0] run_view = zext_ports(run_port_clock_gate);
    wire logic [31:0] sleep_view = zext_ports(sleep_port_clock_gate);
    wire logic [31:0] deep_view = zext_ports(deep_sleep_port_clock_gate);
    wire logic [31:0] irq_status_view = {{(32-spcg_pkg::IRQ_WIDTH){1'b0}}, irq_status};
    wire logic [31:0] irq_enable_view = {{(32-spcg_pkg::IRQ_WIDTH){1'b0}}, irq_enable};
    wire logic [31:0] merged_sleep = merge_lanes(sleep_view, i_avs_writedata, i_avs_byteenable);
    wire logic [31:0] merged_run = merge_lanes(run_view, i_avs_writedata, i_avs_byteenable);
    wire logic [31:0] merged_deep = merge_lanes(deep_view, i_avs_writedata, i_avs_byteenable);
    wire logic [31:0] merged_cfg = merge_lanes(run_mode_clock_config, i_avs_writedata,
                                               i_avs_byteenable);
    wire logic [31:0] merged_ien = merge_lanes(irq_enable_view, i_avs_writedata,
                                               i_avs_byteenable);
    // Sleep and deep-sleep registers only take over when this bit is set
    wire logic auto_clock_gating_select = run_mode_clock_config[spcg_pkg::CFG_AUTO_GATE_BIT];

    // Upper bits of the gate, interrupt and power state views read as zero; the configuration word reads back whole
    wire logic [31:0] rd_mux =
        hit_run ? run_view :
        hit_sleep ? sleep_view :
        hit_deep ? deep_view :
        hit_cfg ? run_mode_clock_config :
        hit_ists ? irq_status_view :
        hit_ien ? irq_enable_view :
        hit_pwr ? {29'h0000_0000, mode} :
        spcg_pkg::WORD_ZERO;

    // ****************************************
    // Mode selection and gating
    // ****************************************
    wire spcg_pkg::spcg_mode_t req_mode = deep_sync[1] ? spcg_pkg::SPCG_DEEP :
                                           sleep_sync[1] ? spcg_pkg::SPCG_SLEEP :
                                           spcg_pkg::SPCG_RUN;
    always_comb begin
        next_mode = req_mode;
    end

    // Without auto gating the run settings cover every mode
    always_comb begin
        unique case (mode)
            spcg_pkg::SPCG_RUN: gate_now = run_port_clock_gate;
            spcg_pkg::SPCG_SLEEP: begin
                if (auto_clock_gating_select) begin
                    gate_now = sleep_port_clock_gate;
                end else begin
                    gate_now = run_port_clock_gate;
                end
            end
            spcg_pkg::SPCG_DEEP: begin
                if (auto_clock_gating_select) begin
                    gate_now = deep_sleep_port_clock_gate;
                end else begin
                    gate_now = run_port_clock_gate;
                end
            end
            default: gate_now = run_port_clock_gate;
        endcase
    end

    // Registered enable avoids glitches into the port clock gates
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            o_port_clock_en <= spcg_pkg::GATE_RESET[PORTS-1:0];
        end else begin
            o_port_clock_en <= gate_now;
        end
    end

    // Applied mode trails the synchronised request by one edge
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            mode <= spcg_pkg::SPCG_RUN;
        end else begin
            mode <= next_mode;
        end
    end

    // ****************************************
    // Port access fault check
    // ****************************************
    // Checked against the enables the ports really see, whatever the mode
    wire logic port_fault_now = i_port_access && !o_port_clock_en[i_port_select];
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            o_port_fault <= 1'b0;
        end else begin
            o_port_fault <= port_fault_now;
        end
    end

    // ****************************************
    // Register writes
    // ****************************************
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            run_port_clock_gate <= spcg_pkg::GATE_RESET[PORTS-1:0];
        end else if (wr_start && hit_run) begin
            run_port_clock_gate <= merged_run[PORTS-1:0];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            sleep_port_clock_gate <= spcg_pkg::GATE_RESET[PORTS-1:0];
        end else if (wr_start && hit_sleep) begin
            sleep_port_clock_gate <= merged_sleep[PORTS-1:0];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            deep_sleep_port_clock_gate <= spcg_pkg::GATE_RESET[PORTS-1:0];
        end else if (wr_start && hit_deep) begin
            deep_sleep_port_clock_gate <= merged_deep[PORTS-1:0];
        end
    end

    // Configuration word is stored whole; only the auto gating bit is used here
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            run_mode_clock_config <= spcg_pkg::WORD_ZERO;
        end else if (wr_start && hit_cfg) begin
            run_mode_clock_config <= merged_cfg;
        end
    end

    // Only the low lane carries interrupt enables
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            irq_enable <= spcg_pkg::IRQ_RESET;
        end else if (wr_start && hit_ien) begin
            irq_enable <= merged_ien[spcg_pkg::IRQ_WIDTH-1:0];
        end
    end

    // ****************************************
    // Interrupt status: set wins over clear
    // ****************************************
    // A mode change is an event as well, so software can see sleep entry and exit
    wire logic mode_change = (next_mode != mode);
    wire logic [spcg_pkg::IRQ_WIDTH-1:0] irq_set =
        {2'b00, mode_change, port_fault_now};
    // Write-one-to-clear on the low lane; an event in the same cycle still sets
    wire logic [spcg_pkg::IRQ_WIDTH-1:0] irq_clr =
        (wr_start && hit_iclr && i_avs_byteenable[0])
        ? i_avs_writedata[spcg_pkg::IRQ_WIDTH-1:0] : spcg_pkg::IRQ_RESET;
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            irq_status <= spcg_pkg::IRQ_RESET;
        end else begin
            irq_status <= (irq_status & ~irq_clr) | irq_set;
        end
    end
    assign o_irq = |(irq_status & irq_enable);

    // ****************************************
    // Bus answer: one wait cycle, then done
    // ****************************************
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            bus_state <= spcg_pkg::SPCG_IDLE;
        end else begin
            unique case (bus_state)
                spcg_pkg::SPCG_IDLE: begin
                    if (access_start) begin
                        bus_state <= spcg_pkg::SPCG_DONE;
                    end
                end
                spcg_pkg::SPCG_DONE: begin
                    bus_state <= spcg_pkg::SPCG_IDLE;
                end
                default: bus_state <= spcg_pkg::SPCG_IDLE;
            endcase
        end
    end

    // Read data and response are captured at the taking edge and stand until the next access
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            read_word <= spcg_pkg::WORD_ZERO;
            resp <= 2'h0;
        end else if (access_start) begin
            read_word <= i_avs_read ? rd_mux : spcg_pkg::WORD_ZERO;
            // Unmapped offsets answer with a slave error
            resp <= hit_any ? 2'h0 : 2'h2;
        end
    end

    assign o_avs_waitrequest = (i_avs_read | i_avs_write) && (bus_state != spcg_pkg::SPCG_DONE);
    assign o_avs_readdata = read_word;
    assign o_avs_response = resp;
endmodule // spcg_top

// ==== tb/spcg_port_model.sv ====
// Partner model: port module access master seen from the port side
`timescale 1ns/1ns
module spcg_port_model (
    // Clock and request from the bench
    input wire logic i_clk_sys,
    input wire logic i_go,
    input wire logic [2:0] i_sel,
    // Port access side of the gating block
    input wire logic i_port_fault,
    output logic o_port_access,
    output logic [2:0] o_port_select,
    output logic o_faulted
);
    // Select inverts while idle so a stale port number is never mistaken for a live one
    always_ff @(posedge i_clk_sys) begin
        o_port_access <= i_go;
        o_port_select <= i_go ? i_sel : ~o_port_select;
        o_faulted <= i_go ? 1'b0 : (o_faulted | i_port_fault);
    end
endmodule // spcg_port_model

// ==== tb/spcg_assertions.sv ====
// Checker: concurrent assertions on the ports of the gating block
`timescale 1ns/1ns
module spcg_checker #(
    parameter int PORTS = 8
) (
    // Clock, reset and register bus
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic [11:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic [1:0] o_avs_response,
    // Port side
    input wire logic i_port_access,
    input wire logic [2:0] i_port_select,
    input wire logic o_port_fault,
    input wire logic [PORTS-1:0] o_port_clock_en,
    input wire logic o_irq
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    wire logic gate_rd = i_avs_read && !o_avs_waitrequest
                         && i_avs_address == spcg_pkg::OFS_SLEEP_GATE;
    a_reset_gates_off: assert property (disable iff (1'b0)
        !i_reset_n |=> !o_port_clock_en)
        else $error("Clock enables not cleared by reset");
    a_reset_quiet: assert property (disable iff (1'b0)
        !i_reset_n |=> !o_irq && !o_port_fault)
        else $error("Outputs not quiet in reset");
    a_single_wait: assert property (
        (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("Bus answer late");
    a_gated_fault: assert property (
        i_port_access && !o_port_clock_en[i_port_select] |=> o_port_fault)
        else $error("No fault on gated port");
    a_clocked_ok: assert property (
        i_port_access && o_port_clock_en[i_port_select] |=> !o_port_fault)
        else $error("Fault on clocked port");
    a_fault_cause: assert property (o_port_fault |-> $past(i_port_access))
        else $error("Fault without access");
    a_reserved_zero: assert property (gate_rd |-> o_avs_readdata[31:8] == 24'h0)
        else $error("Reserved bits not zero");
    a_gate_resp_ok: assert property (gate_rd |-> o_avs_response == 2'b00)
        else $error("Gate register access refused");
endmodule // spcg_checker
bind spcg_top spcg_checker #(.PORTS(PORTS)) i_spcg_checker (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .o_avs_response(o_avs_response),
    .i_port_access(i_port_access), .i_port_select(i_port_select), .o_port_fault(o_port_fault),
    .o_port_clock_en(o_port_clock_en), .o_irq(o_irq)
);

// ==== tb/spcg_top_tb.sv ====
// Testbench: register access, mode gating and port fault scenarios
`timescale 1ns/1ns
module spcg_top_tb;
    localparam logic [11:0] SG = spcg_pkg::OFS_SLEEP_GATE;
    localparam logic [11:0] CF = spcg_pkg::OFS_CLK_CFG;
    logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, slp = 1'b0, dp = 1'b0, go = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wd = 32'h0, rdv, rdata;
    logic [2:0] psel = 3'h0, asel;
    logic [1:0] resp;
    logic [7:0] en;
    logic wait_r, acc, fault, faulted, irq;
    int failures = 0, n_checks = 0;
    always #50 clk = ~clk;
    spcg_top i_spcg_top (
        .i_clk_sys(clk), .i_reset_n(rst_n), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wait_r), .o_avs_response(resp),
        .i_sleep_req(slp), .i_deep_sleep_req(dp), .i_port_access(acc),
        .i_port_select(asel), .o_port_fault(fault), .o_port_clock_en(en), .o_irq(irq));
    spcg_port_model i_spcg_port_model (
        .i_clk_sys(clk), .i_go(go), .i_sel(psel), .i_port_fault(fault),
        .o_port_access(acc), .o_port_select(asel), .o_faulted(faulted));
    task automatic finish_test();
        $display("Checks %0d, failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // Request held until waitrequest is sampled low at a rising edge; read data taken there
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        k = 0;
        @(posedge clk);
        while (wait_r !== 1'b0 && k < 16) begin
            k++;
            @(posedge clk);
        end
        if (wait_r === 1'b0) begin
            rdv = rdata;
            rd <= 1'b0;
            wr <= 1'b0;
        end else begin
            failures++;
            finish_test();
        end
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rdv, e);
    endtask
    // Mode requests pass two sync flops, the mode register and the enable register before the enables follow
    task automatic mode(input logic s, input logic d, input logic [7:0] e);
        @(posedge clk);
        slp <= s;
        dp <= d;
        repeat (6) @(posedge clk);
        chk({24'h0, en}, {24'h0, e});
    endtask
    task automatic port(input logic [2:0] s, input logic e);
        @(posedge clk);
        go <= 1'b1;
        psel <= s;
        @(posedge clk);
        go <= 1'b0;
        repeat (3) @(posedge clk);
        chk({31'h0, faulted}, {31'h0, e});
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk({24'h0, en}, 32'h0);
        rchk(SG, 32'h0);
        bus(1'b1, SG, 32'hFFFF_FFFF);
        rchk(SG, 32'h0000_00FF);
        bus(1'b1, CF, 32'h1 << spcg_pkg::CFG_AUTO_GATE_BIT);
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, SG, 32'h1 << i);
            mode(1'b1, 1'b0, 8'h01 << i);
        end
        bus(1'b1, spcg_pkg::OFS_RUN_GATE, 32'h0F);
        bus(1'b1, spcg_pkg::OFS_DEEP_GATE, 32'h3C);
        bus(1'b1, SG, 32'hA5);
        mode(1'b1, 1'b0, 8'hA5);
        port(3'd1, 1'b1);
        port(3'd0, 1'b0);
        port(3'd7, 1'b0);
        rchk(spcg_pkg::OFS_IRQ_STATUS, 32'h3);
        bus(1'b1, spcg_pkg::OFS_IRQ_ENABLE, 32'h0);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, spcg_pkg::OFS_IRQ_ENABLE, 32'h1);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, spcg_pkg::OFS_IRQ_CLEAR, 32'h1);
        chk({31'h0, irq}, 32'h0);
        mode(1'b1, 1'b1, 8'h3C);
        mode(1'b1, 1'b0, 8'hA5);
        bus(1'b1, CF, 32'h0);
        mode(1'b1, 1'b0, 8'h0F);
        mode(1'b1, 1'b1, 8'h0F);
        mode(1'b0, 1'b0, 8'h0F);
        rchk(12'h3F0, 32'h0);
        chk({30'h0, resp}, 32'h2);
        finish_test();
    end
endmodule // spcg_top_tb
